// ---- logic/fca_pkg.sv ----
package fca_pkg;

  // -----------------------------------------------------------------
  // register map, byte addresses on the apb bus
  // -----------------------------------------------------------------
  localparam logic [11:0] FCA_OFS_CTRL    = 12'h000;
  localparam logic [11:0] FCA_OFS_SELECT  = 12'h004;
  localparam logic [11:0] FCA_OFS_ENABLE  = 12'h008;
  localparam logic [11:0] FCA_OFS_HEIGHT  = 12'h00c;
  localparam logic [11:0] FCA_OFS_STATUS  = 12'h010;
  localparam logic [11:0] FCA_OFS_RESTART = 12'h014;

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int FCA_BIT_MASTER  = 0;
  localparam int FCA_BIT_ENABLE  = 0;
  localparam int FCA_BIT_RESTART = 0;
  localparam int FCA_STAT_CRC_LSB = 16;
  localparam int FCA_STAT_CNT_LSB = 4;
  localparam logic [15:0] FCA_HEIGHT_RST = 16'h0400;
  localparam logic [15:0] FCA_HEIGHT_MAX_LVL = 16'h0400;

  // -----------------------------------------------------------------
  // chunk selector codes and checksum constants
  // -----------------------------------------------------------------
  localparam logic FCA_CHK_LEVELS = 1'h0;
  localparam logic FCA_CHK_CRC = 1'h1;
  localparam logic [15:0] FCA_CRC_POLY = 16'h1021;
  localparam logic [15:0] FCA_CRC_INIT = 16'h0000;

  typedef enum logic [1:0] {
    ST_IMAGE,
    ST_LEVELS,
    ST_CRC_HI,
    ST_CRC_LO
  } fca_state_e;

  // one byte of the frame stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } fca_beat_s;

endpackage

// ---- logic/fca_frame_chunk_appender.sv ----
module fca_frame_chunk_appender #(
  parameter int MAX_LINES = 1024
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineTrig,
  input wire logic [3:0] inputLines,
  input wire logic inValid,
  input wire fca_pkg::fca_beat_s inBeat,
  output logic inReady,
  output logic outValid,
  output fca_pkg::fca_beat_s outBeat,
  input wire logic outReady
);
  import fca_pkg::*;

  localparam int IW = $clog2(MAX_LINES);
  localparam logic [IW:0] MAX_CNT = (IW + 1)'(MAX_LINES);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic rst;
  logic softReq_q;
  logic master_q;
  logic sel_q;
  logic [1:0] chunkEn_q;
  logic [15:0] height_q;
  logic [15:0] lastCrc_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  fca_state_e state_q, state_d;
  logic [MAX_LINES-1:0][3:0] lvlMem_q;
  logic [IW:0] lineCnt_q;
  logic [IW:0] rdIdx_q;
  logic [15:0] crc_q;
  logic firstByte_q;
  logic fLvl_q;
  logic fCrc_q;
  logic outValid_q;
  fca_beat_s outBeat_q;
  logic inReady_q;

  // -----------------------------------------------------------------
  // checksum step
  // -----------------------------------------------------------------
  // msb-first byte update, no reflection, no final xor
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ FCA_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  logic apbSetup, apbAcc, apbWr;
  logic wrEnable, enRefused, mapped;
  logic [15:0] hClamp;
  logic [31:0] rdMux;

  // access phase lasts two cycles; the write lands on the pready edge
  assign apbSetup = psel && penable && !pready_q;
  assign apbAcc = psel && penable && pready_q;
  assign apbWr = apbAcc && pwrite;
  assign wrEnable = apbWr && paddr == FCA_OFS_ENABLE;
  assign enRefused = pwdata[FCA_BIT_ENABLE] && !master_q;
  assign mapped = paddr == FCA_OFS_CTRL || paddr == FCA_OFS_SELECT ||
                  paddr == FCA_OFS_ENABLE || paddr == FCA_OFS_HEIGHT ||
                  paddr == FCA_OFS_STATUS || paddr == FCA_OFS_RESTART;
  // soft restart is applied one cycle after the write completes
  assign rst = srst || softReq_q;

  // read data mux
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      FCA_OFS_CTRL: rdMux[FCA_BIT_MASTER] = master_q;
      FCA_OFS_SELECT: rdMux[0] = sel_q;
      FCA_OFS_ENABLE: rdMux[FCA_BIT_ENABLE] = chunkEn_q[sel_q];
      FCA_OFS_HEIGHT: rdMux[15:0] = height_q;
      FCA_OFS_STATUS: begin
        rdMux[1:0] = chunkEn_q & {2{master_q}};
        rdMux[FCA_STAT_CNT_LSB +: IW+1] = lineCnt_q;
        rdMux[FCA_STAT_CRC_LSB +: 16] = lastCrc_q;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // handshake and response
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apbSetup;
      pslverr_q <= apbSetup && (!mapped ||
                   (pwrite && paddr == FCA_OFS_ENABLE && enRefused));
      if (apbSetup && !pwrite) begin
        prdata_q <= rdMux;
      end
    end
  end

  // restart strobe, one cycle long; only the external reset resets it
  always_ff @(posedge clk) begin
    if (srst) begin
      softReq_q <= 1'b0;
    end else begin
      softReq_q <= apbWr && paddr == FCA_OFS_RESTART &&
                   pwdata[FCA_BIT_RESTART];
    end
  end

  // -----------------------------------------------------------------
  // volatile configuration
  // -----------------------------------------------------------------
  // height writes are clamped rather than refused while levels run
  always_comb begin
    hClamp = pwdata[15:0];
    if (chunkEn_q[FCA_CHK_LEVELS] && hClamp > FCA_HEIGHT_MAX_LVL) begin
      hClamp = FCA_HEIGHT_MAX_LVL;
    end
  end

  // every setting returns to its reset value on restart
  always_ff @(posedge clk) begin
    if (rst) begin
      master_q <= 1'b0;
      sel_q <= FCA_CHK_LEVELS;
      chunkEn_q <= 2'h0;
      height_q <= FCA_HEIGHT_RST;
    end else begin
      if (apbWr && paddr == FCA_OFS_CTRL) begin
        master_q <= pwdata[FCA_BIT_MASTER];
        if (!pwdata[FCA_BIT_MASTER]) begin
          chunkEn_q <= 2'h0;
        end
      end
      if (apbWr && paddr == FCA_OFS_SELECT) begin
        sel_q <= pwdata[0];
      end
      if (wrEnable && !enRefused) begin
        chunkEn_q[sel_q] <= pwdata[FCA_BIT_ENABLE];
        if (sel_q == FCA_CHK_LEVELS && pwdata[FCA_BIT_ENABLE] &&
            height_q > FCA_HEIGHT_MAX_LVL) begin
          height_q <= FCA_HEIGHT_MAX_LVL;
        end
      end
      if (apbWr && paddr == FCA_OFS_HEIGHT) begin
        height_q <= hClamp;
      end
    end
  end

  // -----------------------------------------------------------------
  // line level capture
  // -----------------------------------------------------------------
  logic capture;
  logic [IW:0] capLimit;
  logic frameEnd;

  // limitation: triggers while chunks stream out are dropped
  always_comb begin
    capLimit = MAX_CNT;
    if ({{(16 - IW - 1){1'b0}}, capLimit} > height_q) begin
      capLimit = height_q[IW:0];
    end
  end
  assign capture = lineTrig && state_q == ST_IMAGE && lineCnt_q < capLimit;

  // record written at the line's own index, bit n is input line n
  always_ff @(posedge clk) begin
    if (rst) begin
      lvlMem_q <= '0;
      lineCnt_q <= '0;
    end else if (frameEnd) begin
      lineCnt_q <= '0;
    end else if (capture) begin
      lvlMem_q[lineCnt_q[IW-1:0]] <= inputLines;
      lineCnt_q <= lineCnt_q + 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // frame sequencer
  // -----------------------------------------------------------------
  logic ld, upd, fLvl, fCrc, lvlGo, pairEnd;
  fca_beat_s beat;
  logic [3:0] nibHi;
  logic [IW:0] rdNext;
  logic outValidNext;

  // enables are frozen at the first image byte of each frame
  assign fLvl = firstByte_q ? (master_q && chunkEn_q[FCA_CHK_LEVELS])
                            : fLvl_q;
  assign fCrc = firstByte_q ? (master_q && chunkEn_q[FCA_CHK_CRC])
                            : fCrc_q;
  assign lvlGo = fLvl && lineCnt_q != '0;
  assign rdNext = rdIdx_q + (IW + 1)'(2);
  assign pairEnd = rdNext >= lineCnt_q;
  assign nibHi = (rdIdx_q + 1'b1 < lineCnt_q) ?
                 lvlMem_q[IW'(rdIdx_q + 1'b1)] : 4'h0;

  // picks the next byte whenever the output slot is empty
  always_comb begin
    ld = 1'b0;
    upd = 1'b0;
    beat = '0;
    state_d = state_q;
    frameEnd = 1'b0;
    if (!outValid_q) begin
      case (state_q)
        ST_IMAGE: begin
          if (inReady_q && inValid) begin
            ld = 1'b1;
            upd = 1'b1;
            beat.data = inBeat.data;
            beat.last = inBeat.last && !lvlGo && !fCrc;
            if (inBeat.last) begin
              if (lvlGo) begin
                state_d = ST_LEVELS;
              end else if (fCrc) begin
                state_d = ST_CRC_HI;
              end else begin
                frameEnd = 1'b1;
              end
            end
          end
        end
        ST_LEVELS: begin
          ld = 1'b1;
          upd = 1'b1;
          beat.data = {nibHi, lvlMem_q[rdIdx_q[IW-1:0]]};
          beat.last = pairEnd && !fCrc_q;
          if (pairEnd) begin
            if (fCrc_q) begin
              state_d = ST_CRC_HI;
            end else begin
              state_d = ST_IMAGE;
              frameEnd = 1'b1;
            end
          end
        end
        ST_CRC_HI: begin
          ld = 1'b1;
          beat.data = crc_q[15:8];
          state_d = ST_CRC_LO;
        end
        ST_CRC_LO: begin
          ld = 1'b1;
          beat.data = crc_q[7:0];
          beat.last = 1'b1;
          state_d = ST_IMAGE;
          frameEnd = 1'b1;
        end
        default: state_d = ST_IMAGE;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IMAGE;
      rdIdx_q <= '0;
      firstByte_q <= 1'b1;
      fLvl_q <= 1'b0;
      fCrc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ld && state_q == ST_IMAGE && firstByte_q) begin
        fLvl_q <= fLvl;
        fCrc_q <= fCrc;
        firstByte_q <= 1'b0;
      end
      if (frameEnd) begin
        firstByte_q <= 1'b1;
      end
      if (frameEnd || state_q == ST_IMAGE) begin
        rdIdx_q <= '0;
      end else if (ld && state_q == ST_LEVELS) begin
        rdIdx_q <= rdNext;
      end
    end
  end

  // running checksum, the checksum bytes themselves are excluded
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_q <= FCA_CRC_INIT;
      lastCrc_q <= FCA_CRC_INIT;
    end else if (frameEnd) begin
      crc_q <= FCA_CRC_INIT;
      lastCrc_q <= upd ? crcByte(crc_q, beat.data) : crc_q;
    end else if (upd) begin
      crc_q <= crcByte(crc_q, beat.data);
    end
  end

  // -----------------------------------------------------------------
  // output stage
  // -----------------------------------------------------------------
  // half rate at most: inReady comes from a flop, so no combinational
  // path runs from outReady back to the source
  assign outValidNext = ld || (outValid_q && !outReady);

  always_ff @(posedge clk) begin
    if (rst) begin
      outValid_q <= 1'b0;
      outBeat_q <= '0;
      inReady_q <= 1'b0;
    end else begin
      outValid_q <= outValidNext;
      if (ld) begin
        outBeat_q <= beat;
      end
      inReady_q <= state_d == ST_IMAGE && !outValidNext;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outBeat = outBeat_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence imgEnd_s;
    ld && state_q == ST_IMAGE && inBeat.last;
  endsequence

  sequence crcHiLoad_s;
    state_q == ST_CRC_HI && !outValid_q;
  endsequence

  level_capture_a: assert property (
    capture |=> lvlMem_q[$past(lineCnt_q[IW-1:0])] == $past(inputLines))
    else $error("line levels not captured");
  enable_gate_a: assert property (
    (chunkEn_q & ~$past(chunkEn_q)) != 2'h0 |-> $past(master_q))
    else $error("chunk enabled without master");
  master_off_a: assert property (
    !master_q && !$past(rst) |-> chunkEn_q == 2'h0)
    else $error("chunk enabled while master off");
  height_cap_a: assert property (
    chunkEn_q[FCA_CHK_LEVELS] |-> height_q <= FCA_HEIGHT_MAX_LVL)
    else $error("height above cap with levels on");
  select_write_a: assert property (
    wrEnable && pwdata[FCA_BIT_ENABLE] && master_q
    |=> chunkEn_q[$past(sel_q)])
    else $error("selected chunk not enabled");
  levels_follow_a: assert property (
    imgEnd_s and (lvlGo) |=> state_q == ST_LEVELS)
    else $error("level chunk missing after image");
  crc_follow_a: assert property (
    imgEnd_s and (!lvlGo && fCrc) |=> state_q == ST_CRC_HI)
    else $error("crc chunk missing after image");
  crc_high_a: assert property (
    crcHiLoad_s |=> outValid_q && outBeat_q.data == $past(crc_q[15:8])
    ##[1:1000] (outValid_q && outBeat_q.last &&
                outBeat_q.data == lastCrc_q[7:0]))
    else $error("crc bytes wrong");
  crc_last_a: assert property (
    ld && beat.last && fCrc |-> state_q == ST_CRC_LO)
    else $error("last byte is not the crc");
  soft_clear_a: assert property (@(posedge clk) disable iff (srst)
    softReq_q |=> !master_q && chunkEn_q == 2'h0 &&
    height_q == FCA_HEIGHT_RST)
    else $error("restart kept settings");

endmodule

// ---- verification/fca_host_model.sv ----
// receiving end of the frame stream: collects each frame and checks
// its trailing checksum the way the host software would
module fca_host_model
  import fca_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic outValid,
  input wire fca_pkg::fca_beat_s outBeat,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rxBytes[$];
  logic [7:0] curBytes[$];
  int nFrames = 0;
  logic crcOk = 1'b0;
  logic [1:0] stallCnt = 2'h0;

  // -----------------------------------------------------------------
  // checksum, msb first, zero start, no final inversion
  // -----------------------------------------------------------------
  function automatic logic [15:0] crc_of(input logic [7:0] q[$],
                                         input int n);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < n; i++) begin
      c = c ^ {q[i], 8'h00};
      for (int b = 0; b < 8; b++) begin
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
    end
    return c;
  endfunction

  // -----------------------------------------------------------------
  // sink side
  // -----------------------------------------------------------------
  // a slow host drops ready one cycle in four to stall the framer
  always @(posedge clk) begin
    stallCnt <= stallCnt + 2'h1;
    outReady <= !(slow && stallCnt == 2'h0);
  end

  // frame assembly; verdict only meaningful on frames with a checksum
  always @(posedge clk) begin
    if (!srst && outValid === 1'b1 && outReady === 1'b1) begin
      curBytes.push_back(outBeat.data);
      if (outBeat.last === 1'b1) begin
        rxBytes = curBytes;
        crcOk = (rxBytes.size() >= 2) &&
          (crc_of(rxBytes, rxBytes.size() - 2) ===
           {rxBytes[rxBytes.size() - 2], rxBytes[rxBytes.size() - 1]});
        curBytes.delete();
        nFrames++;
      end
    end
  end
endmodule

// ---- verification/testbench.sv ----
module testbench;
  import fca_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lineTrig = 1'b0;
  logic [3:0] inputLines = 4'h0;
  logic inValid = 1'b0;
  fca_beat_s inBeat = '0;
  logic inReady;
  logic outValid;
  fca_beat_s outBeat;
  logic outReady;
  logic slow = 1'b0;
  int nFail = 0;
  int numChecks = 0;
  int cycles = 0;

  // -----------------------------------------------------------------
  // design and host
  // -----------------------------------------------------------------
  fca_frame_chunk_appender #(.MAX_LINES(1024)) dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lineTrig(lineTrig),
    .inputLines(inputLines), .inValid(inValid), .inBeat(inBeat),
    .inReady(inReady), .outValid(outValid), .outBeat(outBeat),
    .outReady(outReady)
  );

  fca_host_model host (
    .clk(clk), .srst(srst), .slow(slow), .outValid(outValid),
    .outBeat(outBeat), .outReady(outReady)
  );

  // -----------------------------------------------------------------
  // clock, watchdog and verdict
  // -----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    if (nFail == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      end_of_test();
    end
  end

  // -----------------------------------------------------------------
  // access tasks
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error flag", {31'h0, expErr}, {31'h0, e});
  endtask

  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(n, exp, r);
    chk("read error flag", {31'h0, expErr}, {31'h0, e});
  endtask

  // one line trigger; levels inverted after the trigger cycle
  task automatic trig(input logic [3:0] lv);
    @(posedge clk);
    lineTrig <= 1'b1;
    inputLines <= lv;
    @(posedge clk);
    lineTrig <= 1'b0;
    inputLines <= ~lv;
  endtask

  task automatic send(input logic [7:0] img[$]);
    @(posedge clk);
    inValid <= 1'b1;
    foreach (img[i]) begin
      inBeat <= '{data: img[i], last: (i == img.size() - 1)};
      @(posedge clk);
      while (inReady !== 1'b1) @(posedge clk);
    end
    inValid <= 1'b0;
  endtask

  task automatic chk_frame(input int k, input logic [7:0] ex[$]);
    wait (host.nFrames == k);
    chk("frame length", ex.size(), host.rxBytes.size());
    foreach (ex[i]) chk("frame byte", {24'h0, ex[i]}, host.rxBytes[i]);
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic e;
    logic [7:0] ex[$];
    logic [15:0] c;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rdc("height reset", FCA_OFS_HEIGHT, 32'h0000_0400, 1'b0);
    rdc("master reset", FCA_OFS_CTRL, 32'h0, 1'b0);
    wr(FCA_OFS_ENABLE, 32'h1, 1'b1);
    rdc("refused enable", FCA_OFS_ENABLE, 32'h0, 1'b0);
    rdc("unmapped read", 12'h020, 32'h0, 1'b1);
    wr(FCA_OFS_CTRL, 32'h1, 1'b0);
    wr(FCA_OFS_SELECT, {31'h0, FCA_CHK_LEVELS}, 1'b0);
    wr(FCA_OFS_ENABLE, 32'h1, 1'b0);
    wr(FCA_OFS_SELECT, {31'h0, FCA_CHK_CRC}, 1'b0);
    wr(FCA_OFS_ENABLE, 32'h1, 1'b0);
    wr(FCA_OFS_HEIGHT, 32'h0000_0800, 1'b0);
    rdc("height cap", FCA_OFS_HEIGHT, 32'h0000_0400, 1'b0);
    apb(1'b0, FCA_OFS_STATUS, 32'h0, d, e);
    chk("enables on", 32'h3, {30'h0, d[1:0]});
    // both chunks, odd line count, host stalling
    slow <= 1'b1;
    trig(4'h1);
    trig(4'ha);
    trig(4'hf);
    send('{8'h12, 8'h34, 8'h56, 8'h78});
    ex = '{8'h12, 8'h34, 8'h56, 8'h78, 8'ha1, 8'h0f};
    c = host.crc_of(ex, ex.size());
    ex.push_back(c[15:8]);
    ex.push_back(c[7:0]);
    chk_frame(1, ex);
    chk("host verdict", 32'h1, {31'h0, host.crcOk});
    apb(1'b0, FCA_OFS_STATUS, 32'h0, d, e);
    chk("status crc", {16'h0, c}, {16'h0, d[FCA_STAT_CRC_LSB +: 16]});
    // levels only, checksum switched off
    wr(FCA_OFS_ENABLE, 32'h0, 1'b0);
    trig(4'h5);
    trig(4'h6);
    trig(4'h3);
    send('{8'h9c});
    chk_frame(2, '{8'h9c, 8'h65, 8'h03});
    // master off drops every chunk
    wr(FCA_OFS_CTRL, 32'h0, 1'b0);
    wr(FCA_OFS_SELECT, {31'h0, FCA_CHK_LEVELS}, 1'b0);
    rdc("enable after master off", FCA_OFS_ENABLE, 32'h0, 1'b0);
    trig(4'h7);
    send('{8'h3c});
    chk_frame(3, '{8'h3c});
    // restart wipes volatile settings
    wr(FCA_OFS_CTRL, 32'h1, 1'b0);
    wr(FCA_OFS_HEIGHT, 32'h0000_0020, 1'b0);
    rdc("height written", FCA_OFS_HEIGHT, 32'h0000_0020, 1'b0);
    wr(FCA_OFS_RESTART, 32'h1, 1'b0);
    repeat (2) @(posedge clk);
    rdc("height after restart", FCA_OFS_HEIGHT, 32'h400, 1'b0);
    rdc("master after restart", FCA_OFS_CTRL, 32'h0, 1'b0);
    end_of_test();
  end
endmodule
